// ===== rtl/lbcs_pkg.sv
package lbcs_pkg;

	// ****************************************
	// Bus cycle status codes
	// ****************************************
	localparam logic [2:0] ST_INTA    = 3'h0;
	localparam logic [2:0] ST_IO_RD   = 3'h1;
	localparam logic [2:0] ST_IO_WR   = 3'h2;
	localparam logic [2:0] ST_HALT    = 3'h3;
	localparam logic [2:0] ST_FETCH   = 3'h4;
	localparam logic [2:0] ST_MEM_RD  = 3'h5;
	localparam logic [2:0] ST_MEM_WR  = 3'h6;
	localparam logic [2:0] ST_PASSIVE = 3'h7;

	// ****************************************
	// Reset and idle values, synchroniser width
	// ****************************************
	localparam logic [2:0] UPPER_STATUS_VAL = 3'h0;
	localparam logic       RST_ALE          = 1'h0;
	localparam logic       IDLE_BYTE_EN_N   = 1'h1;
	localparam int         SYNC_W           = 16;

	typedef enum logic [2:0] {
		K_INTA, K_IO_RD, K_IO_WR, K_HALT,
		K_FETCH, K_MEM_RD, K_MEM_WR, K_REFRESH
	} lbcs_kind_t;

	typedef enum logic [1:0] {
		W_WORD, W_EVEN, W_ODD
	} lbcs_width_t;

	typedef struct packed {
		lbcs_kind_t  kind;
		lbcs_width_t width;
		logic        dma;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic [2:0]  cascade;
	} lbcs_req_t;

	function automatic logic [2:0] lbcs_status_code(input lbcs_kind_t k);
		case (k)
			K_INTA:    lbcs_status_code = ST_INTA;
			K_IO_RD:   lbcs_status_code = ST_IO_RD;
			K_IO_WR:   lbcs_status_code = ST_IO_WR;
			K_HALT:    lbcs_status_code = ST_HALT;
			K_FETCH:   lbcs_status_code = ST_FETCH;
			K_MEM_WR:  lbcs_status_code = ST_MEM_WR;
			default:   lbcs_status_code = ST_MEM_RD;
		endcase
	endfunction

	// Returns {address bit zero, upper byte enable (active low)}
	function automatic logic [1:0] lbcs_byte_code(input lbcs_req_t r);
		if (r.kind == K_REFRESH)
			lbcs_byte_code = 2'h3;
		else if (r.width == W_WORD)
			lbcs_byte_code = 2'h0;
		else if (r.width == W_EVEN)
			lbcs_byte_code = 2'h1;
		else
			lbcs_byte_code = 2'h2;
	endfunction

	function automatic logic lbcs_is_write(input lbcs_kind_t k);
		lbcs_is_write = (k == K_IO_WR) || (k == K_MEM_WR);
	endfunction

	function automatic logic lbcs_no_data(input lbcs_kind_t k);
		lbcs_no_data = (k == K_HALT) || (k == K_REFRESH);
	endfunction

endpackage

// ===== rtl/lbcs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module lbcs_sync #(
	parameter int W = 16
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_ff;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s1_ff <= '0;
			q     <= '0;
		end else begin
			s1_ff <= d;
			q     <= s1_ff;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/lbcs_bus.sv
`timescale 1ns/1ns
`default_nettype none
module lbcs_bus import lbcs_pkg::*; #(
	parameter bit NARROW = 1'b0
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        req_valid,
	input  var  lbcs_req_t   req,
	output logic             req_ready,
	output logic             done,
	output logic [15:0]      rd_data,
	output logic             addr19_status6_o,
	output logic             addr19_status6_oe,
	input  wire logic        addr19_status6_i,
	output logic [2:0]       upper_addr_status_o,
	output logic             upper_addr_status_oe,
	input  wire logic [2:0]  upper_addr_status_i,
	output logic [2:0]       top_muxed_addr_data_cascade_o,
	output logic             top_muxed_addr_data_cascade_oe,
	input  wire logic [2:0]  top_muxed_addr_data_cascade_i,
	output logic [12:0]      low_muxed_addr_data_o,
	output logic             low_muxed_addr_data_oe,
	input  wire logic [12:0] low_muxed_addr_data_i,
	output logic [2:0]       bus_cycle_status,
	output logic             ale,
	output logic             upper_byte_enable_n
);
	typedef enum logic [2:0] {S_IDLE, S_T1, S_T2, S_T3, S_TW, S_T4}
		lbcs_state_t;

	lbcs_state_t state_ff;
	lbcs_state_t nxt_state;
	lbcs_req_t   cur_ff;
	lbcs_req_t   nxt_cur;
	logic        accept;
	logic [15:0] pins_sync;
	logic [12:0] nxt_low;
	logic        nxt_low_oe;
	logic [2:0]  nxt_top;
	logic        nxt_top_oe;
	logic [2:0]  nxt_up;
	logic        nxt_s6;
	logic [2:0]  nxt_status;
	logic        nxt_ale;
	logic        nxt_bhe_n;
	logic [1:0]  code;

	// ****************************************
	// Cycle sequencer
	// ****************************************
	assign accept  = req_valid && req_ready;
	assign nxt_cur = accept ? req : cur_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE:  nxt_state = accept ? S_T1 : S_IDLE;
			S_T1:    nxt_state = S_T2;
			S_T2:    nxt_state = S_T3;
			S_T3:    nxt_state = S_TW;
			S_TW:    nxt_state = S_T4;
			S_T4:    nxt_state = S_IDLE;
			default: nxt_state = S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff  <= S_IDLE;
			cur_ff    <= '0;
			req_ready <= 1'b1;
		end else begin
			state_ff  <= nxt_state;
			cur_ff    <= nxt_cur;
			req_ready <= (nxt_state == S_IDLE);
		end
	end

	// ****************************************
	// Pin values for the coming state
	// ****************************************
	always_comb begin
		code       = lbcs_byte_code(nxt_cur);
		nxt_low    = '0;
		nxt_low_oe = 1'b0;
		nxt_top    = '0;
		nxt_top_oe = 1'b0;
		nxt_up     = UPPER_STATUS_VAL;
		nxt_s6     = 1'b0;
		nxt_status = ST_PASSIVE;
		nxt_ale    = 1'b0;
		nxt_bhe_n  = IDLE_BYTE_EN_N;
		if (nxt_state == S_T1) begin
			nxt_ale    = 1'b1;
			nxt_low    = nxt_cur.addr[12:0];
			nxt_low_oe = 1'b1;
			if (!NARROW)
				nxt_low[0] = code[1];
			nxt_top    = nxt_cur.addr[15:13];
			nxt_top_oe = 1'b1;
			nxt_up     = nxt_cur.addr[18:16];
			nxt_s6     = nxt_cur.addr[19];
		end else if (nxt_state != S_IDLE) begin
			// Status 6 tells an observer whose cycle this is
			nxt_s6 = nxt_cur.dma || (nxt_cur.kind == K_REFRESH);
			if (lbcs_is_write(nxt_cur.kind)) begin
				nxt_low    = nxt_cur.wdata[12:0];
				nxt_low_oe = 1'b1;
				nxt_top    = nxt_cur.wdata[15:13];
				nxt_top_oe = 1'b1;
			end
		end
		// Status is withdrawn at T3 so the next code edge is seen cleanly
		if (nxt_state == S_T1 || nxt_state == S_T2)
			nxt_status = lbcs_status_code(nxt_cur.kind);
		if (nxt_state != S_IDLE) begin
			if (NARROW) begin
				// Dedicated address pins, never carrying data; bits 12:8 share the enable and float with bits 7:0 after T1 in reads
				nxt_low[12:8] = nxt_cur.addr[12:8];
				nxt_top       = nxt_cur.addr[15:13];
				nxt_top_oe    = 1'b1;
				if (!lbcs_is_write(nxt_cur.kind) && nxt_state != S_T1)
					nxt_low[7:0] = 8'h00;
				nxt_low_oe = nxt_low_oe || 1'b1;
				if (!lbcs_is_write(nxt_cur.kind) && nxt_state != S_T1)
					nxt_low_oe = 1'b0;
				nxt_bhe_n = (nxt_cur.kind != K_REFRESH);
			end else begin
				nxt_bhe_n = code[0];
			end
			if (nxt_cur.kind == K_INTA) begin
				nxt_top    = nxt_cur.cascade;
				nxt_top_oe = 1'b1;
			end
		end
	end

	// ****************************************
	// Output flops
	// ****************************************
	// Upper pins float under reset: they are test inputs then
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			upper_addr_status_oe <= 1'b0;
			addr19_status6_oe    <= 1'b0;
			upper_addr_status_o  <= UPPER_STATUS_VAL;
			addr19_status6_o     <= 1'b0;
		end else begin
			upper_addr_status_oe <= 1'b1;
			addr19_status6_oe    <= 1'b1;
			upper_addr_status_o  <= nxt_up;
			addr19_status6_o     <= nxt_s6;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			low_muxed_addr_data_o          <= '0;
			low_muxed_addr_data_oe         <= 1'b0;
			top_muxed_addr_data_cascade_o  <= '0;
			top_muxed_addr_data_cascade_oe <= 1'b0;
		end else begin
			low_muxed_addr_data_o          <= nxt_low;
			low_muxed_addr_data_oe         <= nxt_low_oe;
			top_muxed_addr_data_cascade_o  <= nxt_top;
			top_muxed_addr_data_cascade_oe <= nxt_top_oe;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus_cycle_status    <= ST_PASSIVE;
			ale                 <= RST_ALE;
			upper_byte_enable_n <= IDLE_BYTE_EN_N;
		end else begin
			bus_cycle_status    <= nxt_status;
			ale                 <= nxt_ale;
			upper_byte_enable_n <= nxt_bhe_n;
		end
	end

	// ****************************************
	// Read data return
	// ****************************************
	// Pins are resynchronised; the extra wait state covers that latency
	lbcs_sync #(.W(SYNC_W)) u_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.d       ({top_muxed_addr_data_cascade_i, low_muxed_addr_data_i}),
		.q       (pins_sync)
	);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			done    <= 1'b0;
			rd_data <= '0;
		end else begin
			done <= (state_ff == S_T4);
			if (state_ff == S_T4 && !lbcs_is_write(cur_ff.kind)
			    && !lbcs_no_data(cur_ff.kind))
				rd_data <= NARROW ? {8'h00, pins_sync[7:0]} : pins_sync;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	logic busy;
	assign busy = (state_ff != S_IDLE);

	a_ale_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
		ale |=> !ale [*4]) else $error("strobe longer than one state");
	a_status_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
		!busy |-> bus_cycle_status == ST_PASSIVE)
		else $error("status not passive while idle");
	a_status_code: assert property (@(posedge ref_clk) disable iff (!rstn)
		accept |=> bus_cycle_status == lbcs_status_code($past(req.kind))
		##1 bus_cycle_status == lbcs_status_code(cur_ff.kind)
		##1 bus_cycle_status == ST_PASSIVE)
		else $error("wrong cycle status code");
	a_upper_addr: assert property (@(posedge ref_clk) disable iff (!rstn)
		accept |=> upper_addr_status_o == $past(req.addr[18:16])
		##1 upper_addr_status_o == UPPER_STATUS_VAL [*2])
		else $error("upper pins wrong address or status");
	a_status_six: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_ff == S_T2) |-> addr19_status6_o ==
		(cur_ff.dma || cur_ff.kind == K_REFRESH))
		else $error("status six wrong");
	a_low_addr: assert property (@(posedge ref_clk) disable iff (!rstn)
		accept |=> low_muxed_addr_data_oe &&
		low_muxed_addr_data_o[7:1] == $past(req.addr[7:1]) && ale)
		else $error("low address not presented");
	a_write_data: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_ff == S_T2 && lbcs_is_write(cur_ff.kind) && !NARROW &&
		cur_ff.kind != K_INTA) |-> top_muxed_addr_data_cascade_o ==
		cur_ff.wdata[15:13] && low_muxed_addr_data_o == cur_ff.wdata[12:0])
		else $error("write data not on bus");
	a_cascade: assert property (@(posedge ref_clk) disable iff (!rstn)
		(busy && cur_ff.kind == K_INTA) |-> top_muxed_addr_data_cascade_oe
		&& top_muxed_addr_data_cascade_o == cur_ff.cascade)
		else $error("cascade address missing");
	a_mid_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
		(NARROW && busy) |-> low_muxed_addr_data_o[12:8] ==
		cur_ff.addr[12:8]) else $error("middle address not held");
	a_byte_code: assert property (@(posedge ref_clk) disable iff (!rstn)
		(!NARROW && state_ff == S_T1) |-> {low_muxed_addr_data_o[0],
		upper_byte_enable_n} == lbcs_byte_code(cur_ff))
		else $error("byte code wrong");
	a_upper_half: assert property (@(posedge ref_clk) disable iff (!rstn)
		(!NARROW && busy && cur_ff.kind != K_REFRESH &&
		cur_ff.width != W_EVEN) |-> !upper_byte_enable_n)
		else $error("upper byte enable not low");
	a_refresh_pin: assert property (@(posedge ref_clk) disable iff (!rstn)
		(NARROW && busy) |-> upper_byte_enable_n ==
		(cur_ff.kind != K_REFRESH)) else $error("refresh pin wrong");

	c_inta: cover property (@(posedge ref_clk) disable iff (!rstn)
		accept && req.kind == K_INTA ##5 done);
	c_write: cover property (@(posedge ref_clk) disable iff (!rstn)
		accept && req.kind == K_MEM_WR ##5 done);
	c_refresh: cover property (@(posedge ref_clk) disable iff (!rstn)
		accept && req.kind == K_REFRESH);
	c_back: cover property (@(posedge ref_clk) disable iff (!rstn)
		done ##0 accept);
endmodule
`default_nettype wire

// ===== tb/lbcs_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module lbcs_far_model import lbcs_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        ale,
	input  wire logic [2:0]  bus_cycle_status,
	input  wire logic        upper_byte_enable_n,
	input  wire logic [19:0] pin_lvl,
	output logic      [15:0] dq,
	output logic      [19:0] lat_addr,
	output logic             lat_bhe_n
);
	// ****************************************
	// Address latch and read responder
	// ****************************************
	logic [2:0]  rd_cnt_ff;
	logic [15:0] last_ff;
	logic        is_rd;

	assign is_rd = bus_cycle_status == ST_INTA || bus_cycle_status == ST_IO_RD
		|| bus_cycle_status == ST_FETCH || bus_cycle_status == ST_MEM_RD;

	// Latch closes as the strobe falls, so the strobe cycle's value is kept
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_cnt_ff <= 3'h0;
			lat_addr  <= 20'h0;
			lat_bhe_n <= 1'h1;
		end else if (ale) begin
			lat_addr  <= pin_lvl;
			lat_bhe_n <= upper_byte_enable_n;
			rd_cnt_ff <= is_rd ? 3'h4 : 3'h0;
		end else if (rd_cnt_ff != 3'h0) begin
			rd_cnt_ff <= rd_cnt_ff - 3'h1;
		end
	end

	// No pull-ups on the data lines: when not answering, show a moving pattern
	assign dq = (rd_cnt_ff != 3'h0) ? (lat_addr[15:0] ^ 16'hC3A5) : ~last_ff;

	// Reset gives the idle pattern a known start, else it stays unknown
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			last_ff <= 16'h0;
		else
			last_ff <= dq;
	end
endmodule
`default_nettype wire

// ===== tb/test_lbcs_bus.sv
`timescale 1ns/1ns
`default_nettype none
module test_lbcs_bus import lbcs_pkg::*;;
	typedef struct packed {
		lbcs_req_t  r;
		logic [2:0] st;
		logic [1:0] bc;
	} lbcs_row_t;

	logic ref_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0;
	lbcs_req_t req = '0;
	logic req_ready, done, s6_o, s6_oe, up_oe, top_oe, low_oe, ale, bhe_n;
	logic [15:0] rd_data, dq;
	logic [2:0] up_o, top_o, st;
	logic [12:0] low_o;
	logic [19:0] pin_lvl, lat_addr;
	logic lat_bhe_n, n_s6_o, n_up_oe, n_top_oe, n_low_oe, n_s6_oe, n_bhe_n;
	logic [2:0] n_up_o, n_top_o;
	logic [12:0] n_low_o;
	int n_errors = 0, cmp_count = 0;
	lbcs_row_t rows [9];

	always #5 ref_clk = ~ref_clk;

	// Upper pins rest weakly high while undriven, never pulled low in reset
	assign pin_lvl = {s6_oe ? s6_o : 1'b1, up_oe ? up_o : 3'h7,
		top_oe ? top_o : dq[15:13], low_oe ? low_o : dq[12:0]};

	lbcs_bus #(.NARROW(1'b0)) i_lbcs_bus (.ref_clk(ref_clk), .rstn(rstn),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.done(done), .rd_data(rd_data), .addr19_status6_o(s6_o),
		.addr19_status6_oe(s6_oe), .addr19_status6_i(pin_lvl[19]),
		.upper_addr_status_o(up_o), .upper_addr_status_oe(up_oe),
		.upper_addr_status_i(pin_lvl[18:16]),
		.top_muxed_addr_data_cascade_o(top_o),
		.top_muxed_addr_data_cascade_oe(top_oe),
		.top_muxed_addr_data_cascade_i(pin_lvl[15:13]),
		.low_muxed_addr_data_o(low_o), .low_muxed_addr_data_oe(low_oe),
		.low_muxed_addr_data_i(pin_lvl[12:0]), .bus_cycle_status(st),
		.ale(ale), .upper_byte_enable_n(bhe_n));

	lbcs_bus #(.NARROW(1'b1)) i_lbcs_bus_narrow (.ref_clk(ref_clk),
		.rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(),
		.done(), .rd_data(), .addr19_status6_o(n_s6_o),
		.addr19_status6_oe(n_s6_oe), .addr19_status6_i(n_s6_o),
		.upper_addr_status_o(n_up_o), .upper_addr_status_oe(n_up_oe),
		.upper_addr_status_i(n_up_o), .top_muxed_addr_data_cascade_o(n_top_o),
		.top_muxed_addr_data_cascade_oe(n_top_oe),
		.top_muxed_addr_data_cascade_i(n_top_o),
		.low_muxed_addr_data_o(n_low_o), .low_muxed_addr_data_oe(n_low_oe),
		.low_muxed_addr_data_i(n_low_o), .bus_cycle_status(),
		.ale(), .upper_byte_enable_n(n_bhe_n));

	lbcs_far_model i_lbcs_far_model (.ref_clk(ref_clk), .rstn(rstn),
		.ale(ale), .bus_cycle_status(st), .upper_byte_enable_n(bhe_n),
		.pin_lvl(pin_lvl), .dq(dq), .lat_addr(lat_addr),
		.lat_bhe_n(lat_bhe_n));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic give_verdict();
		$display("Comparisons %0d, errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [19:0] e,
		input logic [19:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic lbcs_row_t mk(lbcs_kind_t k, lbcs_width_t w, logic d,
		logic [19:0] a, logic [2:0] s, logic [1:0] bc);
		mk = '{'{k, w, d, a, a[15:0] ^ 16'h5A0F, 3'h5}, s, bc};
	endfunction

	// Starts one cycle; rst_at stops it by reset at that step
	task automatic run_row(input lbcs_row_t w, input int rst_at);
		int i;
		logic wr, rd, dat;
		logic [19:0] la;
		logic [15:0] exp_rd;
		wr = w.r.kind == K_IO_WR || w.r.kind == K_MEM_WR;
		dat = w.r.kind != K_HALT && w.r.kind != K_REFRESH;
		rd = !wr && dat;
		// Acknowledge cycles show the cascade code on the top pins throughout
		la = {w.r.addr[19:1], w.bc[1]};
		if (w.r.kind == K_INTA)
			la[15:13] = w.r.cascade;
		exp_rd = la[15:0] ^ 16'hC3A5;
		if (w.r.kind == K_INTA)
			exp_rd[15:13] = w.r.cascade;
		req = w.r;
		req_valid = 1'b1;
		for (i = 0; i < 20 && req_ready !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 20) begin
			n_errors++;
			give_verdict();
		end
		@(negedge ref_clk);
		req_valid = 1'b0;
		for (i = 0; i < 8; i++) begin
			if (i == rst_at)
				return;
			if (i == 0) begin
				chk("ale T1", 20'h1, ale);
				chk("status T1", w.st, st);
				chk("byte enable", w.bc[0], bhe_n);
				chk("refresh narrow", w.r.kind != K_REFRESH, n_bhe_n);
			end
			if (i == 1) begin
				chk("ale T2", 20'h0, ale);
				chk("s6", w.r.dma || w.r.kind == K_REFRESH, s6_o);
				chk("upper status", 20'h0, up_o);
				chk("n s6", w.r.dma || w.r.kind == K_REFRESH, n_s6_o);
				chk("ad drive", wr, low_oe);
				chk("n ad drive", wr, n_low_oe);
				chk("top drive", wr || w.r.kind == K_INTA, top_oe);
				chk("latched", la, lat_addr);
				chk("latched bhe", w.bc[0], lat_bhe_n);
				chk("refused", 20'h0, req_ready);
			end
			if (i == 2) begin
				chk("status T3", ST_PASSIVE, st);
				if (wr)
					chk("wdata", w.r.wdata, {top_o, low_o});
				if (w.r.kind == K_INTA)
					chk("cascade", w.r.cascade, top_o);
				if (dat)
					chk("mid addr", w.r.addr[12:8], n_low_o[12:8]);
				chk("n top", la[15:13], n_top_o);
			end
			if (done === 1'b1)
				break;
			@(negedge ref_clk);
		end
		chk("done delay", 20'h5, i[19:0]);
		if (rd)
			chk("rd_data", exp_rd, rd_data);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rows[0] = mk(K_MEM_RD, W_WORD, 1'b0, 20'h5A5A4, ST_MEM_RD, 2'h0);
		rows[1] = mk(K_MEM_WR, W_EVEN, 1'b0, 20'hF0F12, ST_MEM_WR, 2'h1);
		rows[2] = mk(K_IO_RD, W_ODD, 1'b0, 20'h0E3B7, ST_IO_RD, 2'h2);
		rows[3] = mk(K_IO_WR, W_WORD, 1'b1, 20'h8C3D6, ST_IO_WR, 2'h0);
		rows[4] = mk(K_FETCH, W_WORD, 1'b0, 20'hFFFF0, ST_FETCH, 2'h0);
		rows[5] = mk(K_INTA, W_WORD, 1'b0, 20'h01C00, ST_INTA, 2'h0);
		rows[6] = mk(K_HALT, W_WORD, 1'b0, 20'h12340, ST_HALT, 2'h0);
		rows[7] = mk(K_REFRESH, W_WORD, 1'b0, 20'h3FFFF, ST_MEM_RD, 2'h3);
		rows[8] = mk(K_MEM_WR, W_ODD, 1'b1, 20'hA5A5B, ST_MEM_WR, 2'h2);
		repeat (2) @(negedge ref_clk);
		rstn = 1'b1;
		// Back to back: each row after the first starts in the done cycle of the last
		foreach (rows[k])
			run_row(rows[k], -1);
		repeat (3) @(negedge ref_clk);
		chk("idle status", ST_PASSIVE, st);
		chk("idle upper", 20'h0, up_o);
		// Reset in mid-cycle, just after the address phase
		run_row(rows[1], 1);
		rstn = 1'b0;
		#1;
		chk("rst status", ST_PASSIVE, st);
		chk("rst ale", 20'h0, ale);
		chk("rst bhe", 20'h1, bhe_n);
		chk("rst oe", 20'h0, {up_oe, s6_oe, low_oe, top_oe});
		chk("rst n oe", 20'h0, {n_up_oe, n_s6_oe, n_low_oe, n_top_oe});
		chk("rst done", 20'h0, done);
		chk("rst ready", 20'h1, req_ready);
		repeat (2) @(negedge ref_clk);
		rstn = 1'b1;
		@(negedge ref_clk);
		chk("upper oe", 20'hF, {up_oe, s6_oe, n_up_oe, n_s6_oe});
		run_row(rows[0], -1);
		give_verdict();
	end
endmodule
`default_nettype wire
